// File: dsg_regs.vh
// register offsets, field positions, reset values for the sync gating block
// assumes inclusion by the gating block and the bench; definitions only
`ifndef DSG_REGS_VH
`define DSG_REGS_VH

// byte addresses (printed offsets are not multiples of four: index * 4)
`define DSG_IDX_GATE       8'h58
`define DSG_IDX_PIN        8'h59
`define DSG_IDX_OSC2       8'h5a
`define DSG_IDX_MASTER     8'h5b
`define DSG_IDX_STATUS     8'h5c
`define DSG_ADDR_W         10
`define DSG_ADDR_GATE      10'h160
`define DSG_ADDR_PIN       10'h164
`define DSG_ADDR_OSC2      10'h168
`define DSG_ADDR_MASTER    10'h16c
`define DSG_ADDR_STATUS    10'h170

// gate control fields
`define DSG_QR_ONESHOT     7
`define DSG_QR_GATE        6
`define DSG_FIR_ONESHOT    5
`define DSG_FIR_GATE       4
`define DSG_TUNE_ONESHOT   1
`define DSG_TUNE_GATE      0
`define DSG_GATE_MASK      8'hf3

// pin sensitivity fields
`define DSG_PIN_EDGE_MODE  1
`define DSG_PIN_RISING     0
`define DSG_PIN_MASK       8'h03

// oscillator control two, master enable
`define DSG_LOWLAT_SEL     0
`define DSG_MASTER_EN      0

// reset values
`define DSG_GATE_RST       8'h00
`define DSG_PIN_RST        8'h00
`define DSG_OSC2_RST       8'h01
`define DSG_MASTER_RST     8'h00

// bus responses
`define DSG_RESP_OKAY      2'b00
`define DSG_RESP_SLVERR    2'b10

`endif

// File: dsg_sync_detect.v
// sync pin conditioning: two-flop synchroniser, then level or edge detect
// assumes the pin is asynchronous to clock; outputs one accepted event flag
`timescale 1ns/1ps
`default_nettype none
module dsg_sync_detect (
	// clock and reset
	input  wire clock,
	input  wire rst_n,
	// pin and mode
	input  wire sync_pin,
	input  wire edge_mode,
	input  wire rising,
	// accepted event
	output wire sync_event
);
	reg meta;
	reg stable;
	reg prev;

	// two-flop synchroniser, meta read only by stable
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta   <= 1'b0;
			stable <= 1'b0;
			prev   <= 1'b0;
		end else begin
			meta   <= sync_pin;
			stable <= meta;
			prev   <= stable;
		end
	end

	// level: high pin; edge: selected transition
	assign sync_event = !edge_mode ? stable :
		(rising ? (stable & ~prev) : (~stable & prev));
endmodule // dsg_sync_detect
`default_nettype wire

// File: dsg_sync_gating.v
// sync distribution: axi4-lite registers, per-unit gates and one-shot
// assumes a single 50 MHz clock (divided sample clock), async sync pin
// Operation
// - quarter-rate gate resyncs output oscillator continuously
// - fir one-shot syncs only on first event
// - fir gate self-clears after one-shot sync
// - fir gate resyncs half-band on every event
// - tuning one-shot syncs only on first event
// - tuning gate self-clears after one-shot sync
// - tuning gate restarts oscillator from phase offset
// - sensitivity bit: 0 level, 1 edge
// - edge bit: 0 falling, 1 rising
// - low-latency bit selects low-latency oscillator
// - quarter-rate one-shot syncs once, clears gate
// - nothing syncs without master sync enable
`timescale 1ns/1ps
`default_nettype none
`include "dsg_regs.vh"
module dsg_sync_gating (
	// clock and reset
	input  wire        clock,
	input  wire        rst_n,
	// axi4-lite write address
	input  wire [9:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read address
	input  wire [9:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// axi4-lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// sync pin
	input  wire        sync_pin,
	// sub-unit sync pulses and oscillator select
	output reg         quarter_rate_sync,
	output reg         fir_sync,
	output reg         tuning_sync,
	output reg         low_latency_sel
);
	// control registers
	reg [7:0]  gate_ctl;
	reg [7:0]  pin_ctl;
	reg [7:0]  osc_ctl;
	reg        master_en;
	reg [2:0]  sync_seen;
	// write channel holding
	reg        aw_held;
	reg [9:0]  aw_addr;
	reg        w_held;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	// per-unit views: bit 2 quarter-rate, bit 1 fir, bit 0 tuning
	wire [2:0] unit_gate;
	wire [2:0] unit_oneshot;
	wire [2:0] unit_fire;
	wire [2:0] unit_clear;
	// software write strobes
	wire       wr_gate;
	wire       wr_pin;
	wire       wr_osc;
	wire       wr_master;
	// bus and event decode
	wire       sync_event;
	wire       do_write;
	wire       wr_lane0;
	wire       accepted;
	wire [2:0] rd_sel;
	reg  [7:0] next_gate;
	reg  [1:0] next_rresp;
	reg [31:0] next_rdata;

	// register selector codes from the address decode
	localparam [2:0] SEL_GATE   = 3'h0;
	localparam [2:0] SEL_PIN    = 3'h1;
	localparam [2:0] SEL_OSC2   = 3'h2;
	localparam [2:0] SEL_MASTER = 3'h3;
	localparam [2:0] SEL_STATUS = 3'h4;
	localparam [2:0] SEL_NONE   = 3'h7;

	// pin conditioning
	dsg_sync_detect u_detect (
		.clock      (clock),
		.rst_n      (rst_n),
		.sync_pin   (sync_pin),
		.edge_mode  (pin_ctl[`DSG_PIN_EDGE_MODE]),
		.rising     (pin_ctl[`DSG_PIN_RISING]),
		.sync_event (sync_event)
	);

	// address decode shared by read and write
	function [2:0] reg_sel;
		input [9:0] a;
		begin
			case (a)
				`DSG_ADDR_GATE:   reg_sel = SEL_GATE;
				`DSG_ADDR_PIN:    reg_sel = SEL_PIN;
				`DSG_ADDR_OSC2:   reg_sel = SEL_OSC2;
				`DSG_ADDR_MASTER: reg_sel = SEL_MASTER;
				`DSG_ADDR_STATUS: reg_sel = SEL_STATUS;
				default:          reg_sel = SEL_NONE;
			endcase
		end
	endfunction

	// any register behind the address
	function mapped;
		input [9:0] a;
		begin
			mapped = (reg_sel(a) != SEL_NONE);
		end
	endfunction

	// held write address targets exactly the given register
	function wr_to;
		input [9:0] a;
		input [2:0] sel;
		begin
			wr_to = (reg_sel(a) == sel);
		end
	endfunction

	// write channel handshakes, each taken once and held
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign do_write      = aw_held && w_held && !s_axi_bvalid;
	assign wr_lane0      = do_write && w_strb[0];
	assign s_axi_arready = !s_axi_rvalid;

	// decoded write strobes, status is read-only so never written
	assign wr_gate   = wr_lane0 && wr_to(aw_addr, SEL_GATE);
	assign wr_pin    = wr_lane0 && wr_to(aw_addr, SEL_PIN);
	assign wr_osc    = wr_lane0 && wr_to(aw_addr, SEL_OSC2);
	assign wr_master = wr_lane0 && wr_to(aw_addr, SEL_MASTER);
	assign rd_sel    = reg_sel(s_axi_araddr);

	// events gated by master enable, then split per unit
	assign accepted     = sync_event && master_en;
	assign unit_gate    = {gate_ctl[`DSG_QR_GATE], gate_ctl[`DSG_FIR_GATE],
		gate_ctl[`DSG_TUNE_GATE]};
	assign unit_oneshot = {gate_ctl[`DSG_QR_ONESHOT], gate_ctl[`DSG_FIR_ONESHOT],
		gate_ctl[`DSG_TUNE_ONESHOT]};

	// same fire and one-shot logic for every unit
	genvar u;
	generate
		for (u = 0; u < 3; u = u + 1) begin : g_unit
			assign unit_fire[u]  = accepted && unit_gate[u];
			assign unit_clear[u] = unit_fire[u] && unit_oneshot[u];
		end
	endgenerate

	// write address holding, taken once until the write is done
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			aw_addr <= 10'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	// write data holding, taken once until the write is done
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// write response, slverr for holes in the map
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `DSG_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= mapped(aw_addr) ? `DSG_RESP_OKAY : `DSG_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// gate next value: software write first, one-shot self-clear wins
	always @* begin
		next_gate = gate_ctl;
		if (wr_gate)
			next_gate = w_data[7:0] & `DSG_GATE_MASK;
		if (unit_clear[2])
			next_gate[`DSG_QR_GATE] = 1'b0;
		if (unit_clear[1])
			next_gate[`DSG_FIR_GATE] = 1'b0;
		if (unit_clear[0])
			next_gate[`DSG_TUNE_GATE] = 1'b0;
	end

	// gate control register
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			gate_ctl <= `DSG_GATE_RST;
		else
			gate_ctl <= next_gate;
	end

	// pin sensitivity register, reserved bits read zero
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			pin_ctl <= `DSG_PIN_RST;
		else if (wr_pin)
			pin_ctl <= w_data[7:0] & `DSG_PIN_MASK;
	end

	// oscillator control two, only the select bit is kept
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			osc_ctl <= `DSG_OSC2_RST;
		else if (wr_osc)
			osc_ctl <= {7'h00, w_data[`DSG_LOWLAT_SEL]};
	end

	// master sync enable, low keeps every unit quiet
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			master_en <= 1'b0;
		else if (wr_master)
			master_en <= w_data[`DSG_MASTER_EN];
	end

	// read data and response for the addressed register
	always @* begin
		next_rresp = `DSG_RESP_OKAY;
		case (rd_sel)
			SEL_GATE:   next_rdata = {24'h000000, gate_ctl};
			SEL_PIN:    next_rdata = {24'h000000, pin_ctl};
			SEL_OSC2:   next_rdata = {24'h000000, osc_ctl};
			SEL_MASTER: next_rdata = {31'h00000000, master_en};
			SEL_STATUS: next_rdata = {28'h0000000, sync_event, sync_seen};
			default: begin
				next_rdata = 32'h0000_0000;
				next_rresp = `DSG_RESP_SLVERR;
			end
		endcase
	end

	// read channel, rvalid and data stand until rready
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `DSG_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= next_rresp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// registered sync pulses to the units, high for each cycle a unit fired, one edge later
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			quarter_rate_sync <= 1'b0;
			fir_sync          <= 1'b0;
			tuning_sync       <= 1'b0;
		end else begin
			quarter_rate_sync <= unit_fire[2];
			fir_sync          <= unit_fire[1];
			tuning_sync       <= unit_fire[0];
		end
	end

	// oscillator select follows the control bit one edge later
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			low_latency_sel <= 1'b0;
		else
			low_latency_sel <= osc_ctl[`DSG_LOWLAT_SEL];
	end

	// sticky seen flags for status, cleared only by reset
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			sync_seen <= 3'h0;
		else
			sync_seen <= sync_seen | unit_fire;
	end
endmodule // dsg_sync_gating
`default_nettype wire

// File: dsg_sync_gating_asserts.sv
// port checker for the sync gating block
// assumes binding onto dsg_sync_gating, one clock
`timescale 1ns/1ps
`default_nettype none
module dsg_sync_gating_asserts (
	// clock and reset
	input wire logic	clock,
	input wire logic	rst_n,
	// bus handshakes
	input wire logic	s_axi_awvalid,
	input wire logic	s_axi_awready,
	input wire logic	s_axi_wvalid,
	input wire logic	s_axi_wready,
	input wire logic	s_axi_bvalid,
	input wire logic	s_axi_bready,
	input wire logic	s_axi_arvalid,
	input wire logic	s_axi_arready,
	input wire logic	s_axi_rvalid,
	input wire logic	s_axi_rready,
	// pin and unit outputs
	input wire logic	sync_pin,
	input wire logic	quarter_rate_sync,
	input wire logic	fir_sync,
	input wire logic	tuning_sync,
	input wire logic	low_latency_sel
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// bus transfer steps
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// a unit pulse needs pin activity a few edges earlier
	property pin_cause(p);
		p |-> $past(sync_pin, 2) || $past(sync_pin, 3) || $past(sync_pin, 4);
	endproperty
	chk_qr_cause: assert property (pin_cause(quarter_rate_sync)) else $error("qr pulse");
	chk_fir_cause: assert property (pin_cause(fir_sync)) else $error("fir pulse");
	chk_tune_cause: assert property (pin_cause(tuning_sync)) else $error("tune pulse");
	chk_lowlat_reset: assert property ($rose(rst_n) |=> low_latency_sel) else $error("lowlat");
	chk_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid) else $error("no bvalid");
	chk_read_answer: assert property (rd_take |=> s_axi_rvalid) else $error("no rvalid");
	chk_b_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b");
	chk_r_ends: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("r");
	chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready");
endmodule // dsg_sync_gating_asserts
bind dsg_sync_gating dsg_sync_gating_asserts u_chk (.*);
`default_nettype wire

// File: dsg_sync_src.sv
// behavioural external timing source on the sync pin
// assumes the bench calls drive from its main sequence
`timescale 1ns/1ps
`default_nettype none
module dsg_sync_src (
	// clock
	input wire logic	clock,
	// sync pin
	output logic		sync_pin
);
	initial sync_pin = 1'h0;
	// set a level just after an edge, hold it n edges
	task automatic drive(input logic v, input int n);
		@(posedge clock);
		sync_pin <= v;
		repeat (n) @(posedge clock);
	endtask
endmodule // dsg_sync_src
`default_nettype wire

// File: testbench.sv
// self-checking bench for the sync gating block
// assumes dsg_sync_gating, dsg_sync_src and the checker are compiled
`timescale 1ns/1ps
`default_nettype none
`include "dsg_regs.vh"
module testbench;
	logic		clock = 1'h0;
	logic		rst_n = 1'h0;
	logic	[9:0]	s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
	logic	[31:0]	s_axi_wdata = 32'h0, d;
	logic	[3:0]	s_axi_wstrb = 4'hf;
	logic		s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic		s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	wire		s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire	[1:0]	s_axi_bresp, s_axi_rresp;
	wire	[31:0]	s_axi_rdata;
	wire		sync_pin, quarter_rate_sync, fir_sync, tuning_sync, low_latency_sel;
	logic	[7:0]	nq = 8'h0, nf = 8'h0, nt = 8'h0;
	logic	[1:0]	r;
	logic	[23:0]	b;
	logic	[2:0]	md [3] = '{3'h0, 3'h2, 3'h3};
	int		mismatches = 0, checks_done = 0;
	dsg_sync_gating u_dut (.*);
	dsg_sync_src u_src (.*);
	initial forever #10 clock = ~clock;
	// count unit pulses
	always @(posedge clock) begin
		nq <= nq + {7'h0, quarter_rate_sync};
		nf <= nf + {7'h0, fir_sync};
		nt <= nt + {7'h0, tuning_sync};
	end
	task cmp(input [31:0] g, input [31:0] e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input [9:0] a, input [31:0] v);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
		s_axi_bready <= 1'h1;
		do @(posedge clock); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task rd(input [9:0] a);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge clock); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		s_axi_rready <= 1'h1;
		do @(posedge clock); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task rc(input [9:0] a, input [31:0] e);
		rd(a);
		cmp(d, e);
	endtask
	// pulse count deltas since snapshot, same for all three units
	task cn(input [7:0] e);
		cmp({8'h0, {nq, nf, nt} - b}, {8'h0, e, e, e});
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// watchdog
	initial begin
		#100us;
		mismatches++;
		stop_test;
	end
	// main sequence
	initial begin
		repeat (3) @(posedge clock);
		rst_n <= 1'h1;
		rc(`DSG_ADDR_OSC2, 32'h1);
		cmp({31'h0, low_latency_sel}, 32'h1);
		rd(10'h200);
		cmp({30'h0, r}, 32'h2);
		wr(10'h204, 32'h1);
		cmp({30'h0, r}, 32'h2);
		wr(`DSG_ADDR_GATE, 32'hff);
		wr(`DSG_ADDR_STATUS, 32'h0);
		cmp({30'h0, r}, 32'h0);
		rc(`DSG_ADDR_GATE, 32'hf3);
		wr(`DSG_ADDR_OSC2, 32'h0);
		repeat (2) @(negedge clock);
		cmp({31'h0, low_latency_sel}, 32'h0);
		$display("test regs done");
		b = {nq, nf, nt};
		u_src.drive(1'h1, 6);
		u_src.drive(1'h0, 8);
		cn(8'h0);
		rc(`DSG_ADDR_GATE, 32'hf3);
		rc(`DSG_ADDR_STATUS, 32'h0);
		$display("test master off done");
		wr(`DSG_ADDR_MASTER, 32'h1);
		wr(`DSG_ADDR_GATE, 32'h51);
		for (int i = 0; i < 3; i++) begin
			wr(`DSG_ADDR_PIN, {29'h0, md[i]});
			b = {nq, nf, nt};
			u_src.drive(1'h1, 6);
			if (md[i][1]) cn({7'h0, md[i][0]});
			u_src.drive(1'h0, 8);
			cn(md[i][1] ? 8'h1 : 8'h7);
		end
		rc(`DSG_ADDR_STATUS, 32'h7);
		$display("test modes done");
		wr(`DSG_ADDR_GATE, 32'hf3);
		b = {nq, nf, nt};
		repeat (2) begin
			u_src.drive(1'h1, 4);
			u_src.drive(1'h0, 8);
		end
		cn(8'h1);
		rc(`DSG_ADDR_GATE, 32'ha2);
		$display("test one-shot done");
		wr(`DSG_ADDR_OSC2, 32'h1);
		@(negedge clock);
		cmp({31'h0, low_latency_sel}, 32'h1);
		$display("test low-latency done");
		stop_test;
	end
endmodule // testbench
`default_nettype wire
